// ==== pmem_model.sv ====
// program memory model
`timescale 1ns/1ps
module pmem_model #(parameter PCW = 12, parameter IW = 15) (
    input  wire [PCW-1:0] pmem_addr,
    output wire [IW-1:0]  pmem_data
);
    // word carries its address, so a stale or wrong fetch shows
    assign pmem_data = IW'({pmem_addr, 3'h5});
endmodule

// ==== program_sequencer.v ====
// program sequencer: phase clocks, fetch/execute pipeline, pc and stack
`timescale 1ns/1ps
`include "seq_consts.vh"

module program_sequencer #(
    parameter PCW   = 12,
    parameter IW    = 15,
    parameter DEPTH = 6,
    parameter SPW   = 3
) (
    input  wire                   sys_clk,
    input  wire                   nrst,
    input  wire [`REG_ADDR_W-1:0] reg_addr,
    input  wire [7:0]             reg_wdata,
    input  wire                   reg_wr,
    input  wire                   reg_rd,
    output reg  [7:0]             reg_rdata,
    output reg  [PCW-1:0]         pmem_addr,
    input  wire [IW-1:0]          pmem_data,
    output reg  [IW-1:0]          instr_word,
    output reg                    exec_strobe,
    output reg                    exec_dummy,
    input  wire                   dec_jump,
    input  wire                   dec_call,
    input  wire                   dec_ret,
    input  wire                   dec_interrupt_return_instr,
    input  wire                   dec_skip,
    input  wire [PCW-1:0]         dec_target,
    input  wire                   ext_int_n,
    input  wire                   timer_ovf,
    input  wire                   adc_done,
    input  wire                   rc_osc_sel,
    output reg  [3:0]             phase_clocks,
    output reg                    oscillator_out_pin,
    output reg                    oscillator_out_oe,
    output reg                    int_ack
);

    // one-hot phase codes; one ring pass is one instruction cycle
    localparam [3:0] PH_FETCH  = 4'h1;
    localparam [3:0] PH_DECODE = 4'h2;
    localparam [3:0] PH_EXEC   = 4'h4;
    localparam [3:0] PH_WRITE  = 4'h8;

    // depth cut to index width on purpose; DEPTH-1 must fit in SPW bits
    localparam integer   LAST_I   = DEPTH - 1;
    localparam integer   FULL_I   = DEPTH;
    localparam [SPW-1:0] IDX_LAST = LAST_I[SPW-1:0];
    localparam [SPW:0]   CNT_FULL = FULL_I[SPW:0];

    // vectors are 12-bit; narrower counters drop the unused top bits
    localparam [11:0] VEC_RESET_F = `VEC_RESET;
    localparam [11:0] VEC_EXT_F   = `VEC_EXT;
    localparam [11:0] VEC_TMR_F   = `VEC_TMR;
    localparam [11:0] VEC_ADC_F   = `VEC_ADC;

    reg  [3:0]     phase_reg;
    reg  [3:0]     phase_next;
    reg  [PCW-1:0] pc_reg;
    reg  [PCW-1:0] pc_next;
    reg  [IW-1:0]  fetch_reg;
    reg            dummy_reg;
    reg            flush_next;
    reg            push_next;
    reg            pop_next;
    reg            ack_next;
    reg  [PCW-1:0] stack_mem [0:DEPTH-1];
    // index wraps on overflow, count saturates at the depth
    reg  [SPW-1:0] idx_reg;
    reg  [SPW:0]   cnt_reg;
    reg            low_pend_reg;
    reg  [7:0]     low_val_reg;
    reg  [6:0]     intc_reg;
    reg            ext_s1;
    reg            ext_s2;
    reg            ext_s3;
    reg            rc_s1;
    reg            rc_s2;

    wire           cyc_end;
    wire           exec_live;
    wire           stack_full;
    wire [SPW-1:0] idx_top;
    wire           ext_fall;
    wire           ext_pend;
    wire           tmr_pend;
    wire           adc_pend;
    wire           int_take;
    wire [PCW-1:0] pc_page;
    wire           wr_intc;

    // phase ring; the instruction rate is the one-cycle cyc_end enable
    always @* begin
        case (phase_reg)
            PH_FETCH:  phase_next = PH_DECODE;
            PH_DECODE: phase_next = PH_EXEC;
            PH_EXEC:   phase_next = PH_WRITE;
            PH_WRITE:  phase_next = PH_FETCH;
            // an upset code restarts the ring at fetch
            default:   phase_next = PH_FETCH;
        endcase
    end

    always @(posedge sys_clk) begin
        if (!nrst) begin
            phase_reg <= PH_FETCH;
            phase_clocks <= PH_FETCH;
        end else begin
            phase_reg <= phase_next;
            phase_clocks <= phase_next;
        end
    end

    // last phase: every pc, stack and instr_word change lands on this edge; fetch_reg loads at the end of the first phase
    assign cyc_end = (phase_reg == PH_WRITE);

    // pin inputs pass two flops; third flop only feeds the edge detector
    always @(posedge sys_clk) begin
        if (!nrst) begin
            ext_s1 <= 1'b1;
            ext_s2 <= 1'b1;
            ext_s3 <= 1'b1;
            rc_s1 <= 1'b0;
            rc_s2 <= 1'b0;
        end else begin
            ext_s1 <= ext_int_n;
            ext_s2 <= ext_s1;
            ext_s3 <= ext_s2;
            rc_s1 <= rc_osc_sel;
            rc_s2 <= rc_s1;
        end
    end

    assign ext_fall = ext_s3 & ~ext_s2;

    // rc option: pin high through the first phase only, 1:3 duty
    always @(posedge sys_clk) begin
        if (!nrst) begin
            oscillator_out_pin <= 1'b0;
            oscillator_out_oe <= 1'b0;
        end else begin
            oscillator_out_pin <= rc_s2 & cyc_end;
            oscillator_out_oe <= rc_s2;
        end
    end

    assign exec_live = ~dummy_reg;
    assign stack_full = (cnt_reg == CNT_FULL);
    // entry below the index; wraps so a pop after overflow stays in range
    assign idx_top = (idx_reg == {SPW{1'b0}}) ? IDX_LAST : idx_reg - 1'b1;
    // page jump keeps the upper counter bits of the current fetch address
    assign pc_page = {pc_reg[PCW-1:8], low_val_reg};

    assign ext_pend = intc_reg[`INTC_EXT_REQ] & intc_reg[`INTC_EXT_EN];
    assign tmr_pend = intc_reg[`INTC_TMR_REQ] & intc_reg[`INTC_TMR_EN];
    assign adc_pend = intc_reg[`INTC_ADC_REQ] & intc_reg[`INTC_ADC_EN];

    // acknowledge only between real, non-branching instructions
    assign int_take = intc_reg[`INTC_GIE] & (ext_pend | tmr_pend | adc_pend)
                      & ~stack_full & exec_live
                      & ~(dec_jump | dec_call | dec_ret | dec_interrupt_return_instr)
                      & ~dec_skip & ~low_pend_reg;

    // next fetch address chosen at the end of each instruction cycle
    always @* begin
        pc_next = pc_reg + 1'b1;
        flush_next = 1'b0;
        push_next = 1'b0;
        pop_next = 1'b0;
        ack_next = 1'b0;
        if (exec_live && (dec_ret || dec_interrupt_return_instr)) begin
            // popping an empty stack returns stale data by design
            pc_next = stack_mem[idx_top];
            flush_next = 1'b1;
            pop_next = 1'b1;
        end else if (exec_live && (dec_jump || dec_call)) begin
            pc_next = dec_target;
            flush_next = 1'b1;
            push_next = dec_call;
        end else if (low_pend_reg) begin
            // applied even in a dummy cycle; only a live jump, call or return in the same cycle drops the write
            pc_next = pc_page;
            flush_next = 1'b1;
        end else if (exec_live && dec_skip) begin
            flush_next = 1'b1;
        end else if (int_take) begin
            flush_next = 1'b1;
            push_next = 1'b1;
            ack_next = 1'b1;
            // fixed priority: external, then timer, then converter
            if (ext_pend)
                pc_next = VEC_EXT_F[PCW-1:0];
            else if (tmr_pend)
                pc_next = VEC_TMR_F[PCW-1:0];
            else
                pc_next = VEC_ADC_F[PCW-1:0];
        end
    end

    // pc_reg is the fetch address; a skip keeps pc+1 and discards one word
    always @(posedge sys_clk) begin
        if (!nrst) begin
            pc_reg <= VEC_RESET_F[PCW-1:0];
            pmem_addr <= VEC_RESET_F[PCW-1:0];
            // first cycle after reset is a dummy: nothing fetched yet
            dummy_reg <= 1'b1;
            fetch_reg <= {IW{1'b0}};
            instr_word <= {IW{1'b0}};
            exec_dummy <= 1'b1;
            int_ack <= 1'b0;
        end else begin
            int_ack <= 1'b0;
            // memory has the whole first phase to answer the address
            if (phase_reg == PH_FETCH)
                fetch_reg <= pmem_data;
            if (cyc_end) begin
                pc_reg <= pc_next;
                pmem_addr <= pc_next;
                instr_word <= fetch_reg;
                dummy_reg <= flush_next;
                exec_dummy <= flush_next;
                int_ack <= ack_next;
            end
        end
    end

    // decode gets one strobe in the second phase of each real cycle
    always @(posedge sys_clk) begin
        if (!nrst)
            exec_strobe <= 1'b0;
        else
            exec_strobe <= (phase_reg == PH_FETCH) & exec_live;
    end

    // return stack: overflow wraps and overwrites the oldest entry
    // entries carry no reset; the count alone says what is valid
    // pc_reg is already the next address, so no adder is needed here
    always @(posedge sys_clk) begin
        if (!nrst) begin
            idx_reg <= {SPW{1'b0}};
            cnt_reg <= {(SPW+1){1'b0}};
        end else if (cyc_end && push_next) begin
            stack_mem[idx_reg] <= pc_reg;
            idx_reg <= (idx_reg == IDX_LAST) ? {SPW{1'b0}}
                                             : idx_reg + 1'b1;
            if (!stack_full)
                cnt_reg <= cnt_reg + 1'b1;
        end else if (cyc_end && pop_next) begin
            idx_reg <= idx_top;
            if (cnt_reg != {(SPW+1){1'b0}})
                cnt_reg <= cnt_reg - 1'b1;
        end
    end

    // software writes of the low byte wait for the next cycle boundary
    // a write on the boundary edge itself waits one more cycle, so the
    // pending flag must win over the clear
    always @(posedge sys_clk) begin
        if (!nrst) begin
            low_pend_reg <= 1'b0;
            low_val_reg <= `PC_LOW_RST;
        end else if (reg_wr && reg_addr == `OFS_PC_LOW) begin
            low_pend_reg <= 1'b1;
            low_val_reg <= reg_wdata;
        end else if (cyc_end) begin
            low_pend_reg <= 1'b0;
        end
    end

    assign wr_intc = reg_wr && (reg_addr == `OFS_INTC);

    // request flags: hardware set wins over a software clear
    always @(posedge sys_clk) begin
        if (!nrst) begin
            intc_reg <= `INTC_RST;
        end else begin
            if (wr_intc) begin
                intc_reg[3:0] <= reg_wdata[3:0];
                intc_reg[6:4] <= intc_reg[6:4] & reg_wdata[6:4];
            end
            if (cyc_end && ack_next) begin
                intc_reg[`INTC_GIE] <= 1'b0;
                if (ext_pend)
                    intc_reg[`INTC_EXT_REQ] <= 1'b0;
                else if (tmr_pend)
                    intc_reg[`INTC_TMR_REQ] <= 1'b0;
                else
                    intc_reg[`INTC_ADC_REQ] <= 1'b0;
            end
            if (cyc_end && exec_live && dec_interrupt_return_instr)
                intc_reg[`INTC_GIE] <= 1'b1;
            if (ext_fall)
                intc_reg[`INTC_EXT_REQ] <= 1'b1;
            if (timer_ovf)
                intc_reg[`INTC_TMR_REQ] <= 1'b1;
            if (adc_done)
                intc_reg[`INTC_ADC_REQ] <= 1'b1;
        end
    end

    // read data in the cycle after the strobe; stack is not mapped
    // data drops back to zero so a stale read cannot be mistaken
    always @(posedge sys_clk) begin
        if (!nrst) begin
            reg_rdata <= `RDATA_RST;
        end else if (reg_rd) begin
            case (reg_addr)
                // the fetch address, one ahead of the executing word
                `OFS_PC_LOW: reg_rdata <= pc_reg[7:0];
                `OFS_INTC: reg_rdata <= {1'b0, intc_reg};
                default:   reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

endmodule

// ==== program_sequencer_tb.sv ====
// self-checking bench for the program sequencer
`timescale 1ns/1ps
`include "seq_consts.vh"
module program_sequencer_tb;
    logic        sys_clk = 1'h0, nrst = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
    logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic        dec_jump = 1'h0, dec_call = 1'h0, dec_ret = 1'h0;
    logic        dec_interrupt_return_instr = 1'h0, dec_skip = 1'h0, ext_int_n = 1'h1;
    logic        timer_ovf = 1'h0, adc_done = 1'h0, rc_osc_sel = 1'h0;
    logic [11:0] dec_target = 12'h000, pmem_addr, a, f;
    logic [14:0] pmem_data, instr_word;
    logic [3:0]  phase_clocks;
    logic        exec_strobe, exec_dummy, oscillator_out_pin;
    logic        oscillator_out_oe, int_ack;
    int          bad_count = 0, checked = 0, acks = 0, n;
    always #2.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (int_ack === 1'h1) acks <= acks + 1;
    program_sequencer uut (.*);
    pmem_model mem (.pmem_addr(pmem_addr), .pmem_data(pmem_data));
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic give_verdict;
        $display("checked %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // settles just after the edge that opens phase p
    task automatic wph(input logic [3:0] p);
        n = 0;
        do begin
            @(posedge sys_clk);
            #1 n++;
        end while (phase_clocks !== p && n < 40);
        if (n >= 40) begin
            bad_count++;
            give_verdict;
        end
    endtask
    // plays the decoder for one real instruction cycle
    task automatic step(input logic [4:0] k, input logic [11:0] t);
        wph(4'h4);
        if (exec_dummy !== 1'h0)
            wph(4'h4);
        a = pmem_addr;
        @(posedge sys_clk);
        {dec_jump, dec_call, dec_ret, dec_interrupt_return_instr, dec_skip} <= k;
        dec_target <= t;
        @(posedge sys_clk);
        {dec_jump, dec_call, dec_ret, dec_interrupt_return_instr, dec_skip} <= 5'h00;
        #1;
    endtask
    task automatic bus(input logic w, input logic [7:0] ad,
                       input logic [7:0] d);
        @(posedge sys_clk);
        {reg_wr, reg_rd} <= {w, !w};
        reg_addr <= ad;
        reg_wdata <= d;
        @(posedge sys_clk);
        {reg_wr, reg_rd} <= 2'h0;
        #1 if (!w) chk(16'(reg_rdata), 16'(d));
    endtask
    task automatic wack;
        for (int i = 0; i < 8 && int_ack !== 1'h1; i++) begin
            f = pmem_addr;
            wph(4'h1);
        end
        chk(16'(int_ack), 16'h1);
    endtask
    task automatic t_pipe;
        wph(4'h1);
        a = pmem_addr;
        wph(4'h1);
        chk(16'(n), 16'h4);
        chk(16'(pmem_addr), 16'(a + 12'h1));
        chk(16'(instr_word), 16'({a, 3'h5}));
        wph(4'h2);
        chk(16'(exec_strobe), 16'h1);
        step(5'h10, 12'h3a7);
        chk(16'({exec_dummy, pmem_addr}), 16'h13a7);
        wph(4'h2);
        chk(16'(exec_strobe), 16'h0);
        step(5'h01, 12'h000);
        chk(16'({exec_dummy, pmem_addr}), 16'h13a9);
        wph(4'h1);
        bus(1'h1, `OFS_PC_LOW, 8'h40);
        wph(4'h1);
        chk(16'({exec_dummy, pmem_addr}), 16'h1340);
        bus(1'h0, `OFS_PC_LOW, 8'h40);
        bus(1'h0, 8'h7f, 8'h00);
        $display("pipeline test done");
    endtask
    task automatic t_stack;
        for (int i = 0; i < 6; i++)
            step(5'h08, {4'h1, 4'(i), 4'h0});
        bus(1'h1, `OFS_INTC, 8'h0f);
        @(posedge sys_clk);
        ext_int_n <= 1'h0;
        repeat (4) wph(4'h1);
        chk(16'(acks), 16'h0);
        step(5'h04, 12'h000);
        chk(16'(pmem_addr), 16'h0141);
        wack;
        chk(16'(pmem_addr), 16'(`VEC_EXT));
        @(posedge sys_clk);
        ext_int_n <= 1'h1;
        step(5'h02, 12'h000);
        chk(16'(pmem_addr), 16'(f));
        for (int i = 0; i < 2; i++) begin
            @(posedge sys_clk);
            {adc_done, timer_ovf} <= 2'(i + 1);
            @(posedge sys_clk);
            {adc_done, timer_ovf} <= 2'h0;
            wack;
            f = `VEC_TMR + 12'(i * 4);
            chk(16'(pmem_addr), 16'(f));
            step(5'h02, 12'h000);
        end
        chk(16'(acks), 16'h3);
        $display("stack and interrupt test done");
    endtask
    task automatic t_rc;
        int k = 0;
        @(posedge sys_clk);
        rc_osc_sel <= 1'h1;
        repeat (8) @(posedge sys_clk);
        repeat (8) begin
            @(posedge sys_clk);
            #1 k += int'(oscillator_out_pin === 1'h1);
        end
        chk(16'(k), 16'h2);
        chk(16'(oscillator_out_oe), 16'h1);
        $display("rc pin test done");
    endtask
    initial begin
        repeat (12) @(posedge sys_clk);
        nrst <= 1'h1;
        #1;
        chk(16'({phase_clocks, exec_dummy, pmem_addr}), 16'h3000);
        bus(1'h0, `OFS_PC_LOW, 8'h00);
        $display("reset test done");
        t_pipe;
        t_stack;
        t_rc;
        give_verdict;
    end
endmodule

// ==== seq_chk.sv ====
// port checker for the program sequencer
`timescale 1ns/1ps
`include "seq_consts.vh"
module seq_chk #(parameter PCW = 12) (
    input wire           sys_clk,
    input wire           nrst,
    input wire           reg_rd,
    input wire [7:0]     reg_addr,
    input wire [7:0]     reg_rdata,
    input wire [PCW-1:0] pmem_addr,
    input wire [PCW-1:0] dec_target,
    input wire           exec_strobe,
    input wire           exec_dummy,
    input wire           dec_jump,
    input wire           dec_call,
    input wire           dec_ret,
    input wire           dec_interrupt_return_instr,
    input wire           dec_skip,
    input wire [3:0]     phase_clocks,
    input wire           oscillator_out_pin,
    input wire           oscillator_out_oe,
    input wire           int_ack
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    wire       t4    = phase_clocks == 4'h8 && !exec_dummy;
    wire       brn   = dec_jump | dec_call | dec_ret | dec_interrupt_return_instr;
    wire [7:0] pc_lo = pmem_addr[7:0];
    a_phase_onehot: assert property ($onehot(phase_clocks))
        else $error("phase not one-hot");
    a_phase_walk: assert property (phase_clocks == 4'h1 |=>
        phase_clocks == 4'h2 ##1 phase_clocks == 4'h4
        ##1 phase_clocks == 4'h8)
        else $error("phase order broken");
    a_addr_hold: assert property (
        phase_clocks != 4'h8 |=> $stable(pmem_addr))
        else $error("fetch address moved mid cycle");
    a_jump_load: assert property (
        t4 && (dec_jump | dec_call) && !dec_ret && !dec_interrupt_return_instr |=>
        pmem_addr == $past(dec_target) && exec_dummy)
        else $error("jump target not loaded");
    a_skip_two: assert property (
        t4 && dec_skip && !brn |=> exec_dummy &&
        pmem_addr == $past(pmem_addr) + 1'b1)
        else $error("skip not handled");
    a_strobe_real: assert property (exec_strobe |->
        phase_clocks == 4'h2 && !exec_dummy)
        else $error("strobe out of place");
    a_ack_vector: assert property (
        int_ack |-> phase_clocks == 4'h1 && exec_dummy &&
        pmem_addr inside {`VEC_EXT, `VEC_TMR, `VEC_ADC})
        else $error("ack without vector");
    a_low_read: assert property (
        reg_rd && reg_addr == `OFS_PC_LOW && phase_clocks != 4'h8
        |=> reg_rdata == $past(pc_lo))
        else $error("low byte read wrong");
    a_rdata_idle: assert property (
        !$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data not idle");
    a_osc_phase: assert property (oscillator_out_oe |->
        oscillator_out_pin == phase_clocks[0])
        else $error("osc pin not first phase");
    c_ack: cover property (int_ack);
    c_skip: cover property (t4 && dec_skip);
    c_osc: cover property (oscillator_out_oe && oscillator_out_pin);
endmodule
bind program_sequencer seq_chk #(.PCW(PCW)) u_chk (.*);

// ==== seq_consts.vh ====
// constants for the program sequencer: offsets, fields, resets, vectors
`ifndef SEQ_CONSTS_VH
`define SEQ_CONSTS_VH

`define REG_ADDR_W      8
`define OFS_PC_LOW      8'h02
`define OFS_INTC        8'h0b

`define PC_LOW_RST      8'h00
`define INTC_RST        7'h00
`define RDATA_RST       8'h00

`define INTC_GIE        0
`define INTC_EXT_EN     1
`define INTC_TMR_EN     2
`define INTC_ADC_EN     3
`define INTC_EXT_REQ    4
`define INTC_TMR_REQ    5
`define INTC_ADC_REQ    6

`define VEC_RESET       12'h000
`define VEC_EXT         12'h004
`define VEC_TMR         12'h008
`define VEC_ADC         12'h00c

`define PHASE_COUNT     4

`endif
